// [shared/ccl_pkg.sv]
/*
 * Constants and types for the calibration coefficient loader: coefficient
 * store layout, lookup table bases, fixed word locations, lock codes and
 * the refresh period.
 * Assumes a single 250 MHz clock and a byte-wide coefficient store.
 */
// How it works
// - Offset table holds 176 16-bit entries chosen by temperature index.
// - While locked, each millisecond the indexed offset entry loads the offset DAC.
// - Lowest index is zero; colder temperatures use entry 00hex.
// - Highest index is AFhex; hotter readings saturate, never wrap.
// - Span DAC loads from its own 176-entry table, same index and clamp.
// - Offset TC and span TC registers hold 16-bit first-order codes.
// - A config bit picks internal or external span feedback resistors.
// - Every coefficient register accepts any code 0000hex to FFFFhex.
// - Five 16-bit calibration registers load from store or serial path.
// - Locked (FFhex, pin low) after reset: config and TC words load.
// - Same power-on pass loads offset and span DAC from indexed words.
// - Locked operation reloads all five registers every 1 ms period.
// - Lock 00hex or override pin high lets the host write registers.
// - Coefficient store is 768 bytes in 12 pages of 64 bytes.
// - Each page can be erased alone without touching other pages.
// - Offset table occupies bytes 000hex through 15Fhex contiguously.
// - Span table splits over 200hex-2FFhex and 1A0hex-1FFhex.
// - Stored values are two adjacent bytes, low byte then high byte.
// - Temperature index is taken as an 8-bit value every 1 ms.
// - Each index value addresses two store bytes.
// - Lock byte 00hex turns the serial line into a calibration input.
package ccl_pkg;

   // ***************************************************************
   // Coefficient store geometry
   // ***************************************************************
   localparam int unsigned CCL_EE_BYTES   = 768;
   localparam int unsigned CCL_EE_PAGES   = 12;
   localparam int unsigned CCL_PAGE_BYTES = 64;
   localparam int unsigned CCL_AW         = 10;
   localparam int unsigned CCL_PW         = 4;
   localparam int unsigned CCL_PAGE_SHIFT = 6;

   // ***************************************************************
   // Table and word locations
   // ***************************************************************
   localparam logic [9:0] CCL_OFF_BASE     = 10'h000;
   localparam logic [9:0] CCL_SPAN_LO_BASE = 10'h200;
   localparam logic [9:0] CCL_SPAN_HI_BASE = 10'h1a0;
   localparam logic [7:0] CCL_SPAN_SPLIT   = 8'h80;
   localparam logic [7:0] CCL_IDX_MAX      = 8'haf;
   localparam logic [9:0] CCL_CONFIG_ADDR  = 10'h160;
   localparam logic [9:0] CCL_OTC_ADDR     = 10'h164;
   localparam logic [9:0] CCL_STC_ADDR     = 10'h168;
   localparam logic [9:0] CCL_LOCK_ADDR    = 10'h16a;

   // ***************************************************************
   // Lock codes and configuration fields
   // ***************************************************************
   localparam logic [7:0] CCL_LOCK_SET   = 8'hff;
   localparam logic [7:0] CCL_LOCK_OPEN  = 8'h00;
   localparam int unsigned CCL_CFG_EXT_RES_BIT = 0;
   localparam logic [15:0] CCL_REG_RST   = 16'h0000;

   // ***************************************************************
   // Load sequence steps: byte 0 is the lock byte, then five words
   // ***************************************************************
   localparam logic [3:0] CCL_STEP_LOCK  = 4'h0;
   localparam logic [3:0] CCL_STEP_FIRST = 4'h2;
   localparam logic [3:0] CCL_STEP_LAST  = 4'hb;
   localparam logic [2:0] CCL_SEL_CONFIG = 3'h1;
   localparam logic [2:0] CCL_SEL_OTC    = 3'h2;
   localparam logic [2:0] CCL_SEL_STC    = 3'h3;
   localparam logic [2:0] CCL_SEL_OFF    = 3'h4;
   localparam logic [2:0] CCL_SEL_SPAN   = 3'h5;

   // ***************************************************************
   // Timing
   // ***************************************************************
   localparam int unsigned CCL_CLK_HZ      = 250_000_000;
   localparam int unsigned CCL_REFRESH_US  = 1000;
   localparam int unsigned CCL_REFRESH_CYC =
      (CCL_CLK_HZ / 1_000_000) * CCL_REFRESH_US;

   typedef enum logic [1:0] {
      CCL_ST_IDLE,
      CCL_ST_ADDR,
      CCL_ST_DATA
   } ccl_state_t;

   typedef struct packed {
      logic [15:0] config_word;
      logic [15:0] offset_tc_dac_reg;
      logic [15:0] span_tc_dac_reg;
      logic [15:0] offset_dac_reg;
      logic [15:0] span_dac_reg;
   } ccl_cal_regs_t;

   typedef struct packed {
      logic        valid;
      logic [2:0]  sel;
      logic [15:0] data;
   } ccl_cal_wr_t;

   typedef struct packed {
      logic        wr;
      logic [9:0]  addr;
      logic [7:0]  data;
      logic        erase;
      logic [3:0]  page;
   } ccl_ee_prog_t;

endpackage

// [rtl/ccl_eeprom.sv]
/*
 * Byte-wide coefficient store with registered read, byte write and
 * single-page erase.
 * Assumes program and erase timing is handled outside; both act in one cycle.
 */
`timescale 1ns/1ps
module ccl_eeprom (
   input  wire logic       clk_in,
   input  wire logic       rd_en_in,
   input  wire logic [9:0] rd_addr_in,
   output logic      [7:0] rd_data_out,
   input  wire logic       wr_en_in,
   input  wire logic [9:0] wr_addr_in,
   input  wire logic [7:0] wr_data_in,
   input  wire logic       erase_in,
   input  wire logic [3:0] erase_page_in
);

   // ***************************************************************
   // Storage
   // ***************************************************************
   // No reset on the array: contents are meant to survive reset
   logic [7:0] mem_q [ccl_pkg::CCL_EE_BYTES];
   logic [7:0] rd_data_q;

   assign rd_data_out = rd_data_q;

   always_ff @(posedge clk_in) begin
      for (int i = 0; i < int'(ccl_pkg::CCL_EE_BYTES); i++) begin
         if (erase_in && erase_page_in < 4'(ccl_pkg::CCL_EE_PAGES) &&
             (i >> ccl_pkg::CCL_PAGE_SHIFT) == int'(erase_page_in)) begin
            mem_q[i] <= 8'hff;
         end else if (wr_en_in && !erase_in && int'(wr_addr_in) == i) begin
            mem_q[i] <= wr_data_in;
         end
      end
      if (rd_en_in && rd_addr_in < 10'(ccl_pkg::CCL_EE_BYTES)) begin
         rd_data_q <= mem_q[rd_addr_in];
      end else if (rd_en_in) begin
         rd_data_q <= 8'hff;
      end
   end

endmodule

// [rtl/ccl_loader.sv]
/*
 * Calibration coefficient loader: reads the lock byte and five 16-bit
 * calibration words from the coefficient store after reset and every
 * refresh period, or takes them from the serial calibration path.
 * Assumes the temperature index and serial writes are synchronous to clk_in.
 */
`timescale 1ns/1ps
module ccl_loader #(
   parameter int unsigned REFRESH_CYC = ccl_pkg::CCL_REFRESH_CYC
) (
   input  wire logic                  clk_in,
   input  wire logic                  rst_in,
   input  wire logic [7:0]            temp_index_in,
   input  wire logic                  unlock_in,
   input  wire ccl_pkg::ccl_cal_wr_t  cal_wr_in,
   input  wire ccl_pkg::ccl_ee_prog_t ee_prog_in,
   output ccl_pkg::ccl_cal_regs_t     cal_regs_out,
   output logic [7:0]                 temp_index_out,
   output logic                       cal_access_out,
   output logic                       locked_out,
   output logic                       ext_res_sel_out,
   output logic                       load_busy_out,
   output logic                       load_done_out
);

   // ***************************************************************
   // Refresh timer
   // ***************************************************************
   logic [31:0] timer_q;
   logic [31:0] timer_d;
   logic        tick;

   always_comb begin
      tick    = (timer_q == REFRESH_CYC - 1);
      timer_d = tick ? 32'h0000_0000 : timer_q + 32'h0000_0001;
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         timer_q <= 32'h0000_0000;
      end else begin
         timer_q <= timer_d;
      end
   end

   // ***************************************************************
   // Load sequencer state
   // ***************************************************************
   ccl_pkg::ccl_state_t    state_q;
   ccl_pkg::ccl_state_t    state_d;
   logic [3:0]             step_q;
   logic [3:0]             step_d;
   logic                   pend_q;
   logic                   pend_d;
   logic [7:0]             idx_q;
   logic [7:0]             idx_d;
   logic [7:0]             lo_q;
   logic [7:0]             lo_d;
   logic                   lock_open_q;
   logic                   lock_open_d;
   logic                   lock_set_q;
   logic                   lock_set_d;
   logic                   done_q;
   logic                   done_d;
   ccl_pkg::ccl_cal_regs_t regs_q;
   ccl_pkg::ccl_cal_regs_t regs_d;

   logic       rd_en;
   logic [9:0] rd_addr;
   logic [7:0] rd_data;
   logic [2:0] sel;
   logic [9:0] word_addr;
   logic [15:0] word;
   logic       cal_access;

   ccl_eeprom u_store (
      .clk_in        (clk_in),
      .rd_en_in      (rd_en),
      .rd_addr_in    (rd_addr),
      .rd_data_out   (rd_data),
      .wr_en_in      (ee_prog_in.wr),
      .wr_addr_in    (ee_prog_in.addr),
      .wr_data_in    (ee_prog_in.data),
      .erase_in      (ee_prog_in.erase),
      .erase_page_in (ee_prog_in.page)
   );

   // ***************************************************************
   // Address formation
   // ***************************************************************
   always_comb begin
      sel = step_q[3:1];
      case (sel)
         ccl_pkg::CCL_SEL_CONFIG: word_addr = ccl_pkg::CCL_CONFIG_ADDR;
         ccl_pkg::CCL_SEL_OTC:    word_addr = ccl_pkg::CCL_OTC_ADDR;
         ccl_pkg::CCL_SEL_STC:    word_addr = ccl_pkg::CCL_STC_ADDR;
         ccl_pkg::CCL_SEL_OFF: begin
            word_addr = ccl_pkg::CCL_OFF_BASE + {1'b0, idx_q, 1'b0};
         end
         ccl_pkg::CCL_SEL_SPAN: begin
            if (idx_q < ccl_pkg::CCL_SPAN_SPLIT) begin
               word_addr = ccl_pkg::CCL_SPAN_LO_BASE +
                           {1'b0, idx_q, 1'b0};
            end else begin
               word_addr = ccl_pkg::CCL_SPAN_HI_BASE +
                  {1'b0, idx_q - ccl_pkg::CCL_SPAN_SPLIT, 1'b0};
            end
         end
         default: word_addr = ccl_pkg::CCL_LOCK_ADDR;
      endcase
      // Low byte at the even address, high byte at the odd one
      rd_addr = word_addr | {9'h000, step_q[0]};
      rd_en   = (state_q == ccl_pkg::CCL_ST_ADDR);
      word    = {rd_data, lo_q};
   end

   // Override pin acts at once; the stored lock byte after its next read
   assign cal_access = lock_open_q | unlock_in;

   // ***************************************************************
   // Sequencer and register next state
   // ***************************************************************
   always_comb begin
      state_d     = state_q;
      step_d      = step_q;
      pend_d      = pend_q | tick;
      idx_d       = idx_q;
      lo_d        = lo_q;
      lock_open_d = lock_open_q;
      lock_set_d  = lock_set_q;
      done_d      = 1'b0;
      regs_d      = regs_q;
      case (state_q)
         ccl_pkg::CCL_ST_IDLE: begin
            if (pend_q) begin
               pend_d  = tick;
               state_d = ccl_pkg::CCL_ST_ADDR;
               step_d  = ccl_pkg::CCL_STEP_LOCK;
               // Clamp keeps the index inside the 176-entry tables
               if (temp_index_in > ccl_pkg::CCL_IDX_MAX) begin
                  idx_d = ccl_pkg::CCL_IDX_MAX;
               end else begin
                  idx_d = temp_index_in;
               end
            end
         end
         ccl_pkg::CCL_ST_ADDR: begin
            state_d = ccl_pkg::CCL_ST_DATA;
         end
         ccl_pkg::CCL_ST_DATA: begin
            state_d = ccl_pkg::CCL_ST_ADDR;
            step_d  = step_q + 4'h1;
            if (step_q == ccl_pkg::CCL_STEP_LOCK) begin
               lock_open_d = (rd_data == ccl_pkg::CCL_LOCK_OPEN);
               lock_set_d  = (rd_data == ccl_pkg::CCL_LOCK_SET);
               step_d      = ccl_pkg::CCL_STEP_FIRST;
               // Lock byte not FFhex or override pin high: skip the automatic load
               if (rd_data != ccl_pkg::CCL_LOCK_SET || unlock_in) begin
                  state_d = ccl_pkg::CCL_ST_IDLE;
               end
            end else if (!step_q[0]) begin
               lo_d = rd_data;
            end else begin
               case (sel)
                  ccl_pkg::CCL_SEL_CONFIG: begin
                     regs_d.config_word = word;
                  end
                  ccl_pkg::CCL_SEL_OTC: begin
                     regs_d.offset_tc_dac_reg = word;
                  end
                  ccl_pkg::CCL_SEL_STC: begin
                     regs_d.span_tc_dac_reg = word;
                  end
                  ccl_pkg::CCL_SEL_OFF: begin
                     regs_d.offset_dac_reg = word;
                  end
                  ccl_pkg::CCL_SEL_SPAN: begin
                     regs_d.span_dac_reg = word;
                  end
                  default: regs_d = regs_q;
               endcase
               if (step_q == ccl_pkg::CCL_STEP_LAST) begin
                  state_d = ccl_pkg::CCL_ST_IDLE;
                  done_d  = 1'b1;
               end
            end
         end
         default: state_d = ccl_pkg::CCL_ST_IDLE;
      endcase
      // Override raised mid-pass: drop the rest so serial values persist
      if (unlock_in && state_q != ccl_pkg::CCL_ST_IDLE &&
          step_q != ccl_pkg::CCL_STEP_LOCK) begin
         state_d = ccl_pkg::CCL_ST_IDLE;
         done_d  = 1'b0;
         regs_d  = regs_q;
      end
      // Serial loads take the full 16-bit code range unaltered
      if (cal_wr_in.valid && cal_access) begin
         case (cal_wr_in.sel)
            ccl_pkg::CCL_SEL_CONFIG: regs_d.config_word = cal_wr_in.data;
            ccl_pkg::CCL_SEL_OTC: regs_d.offset_tc_dac_reg = cal_wr_in.data;
            ccl_pkg::CCL_SEL_STC: regs_d.span_tc_dac_reg = cal_wr_in.data;
            ccl_pkg::CCL_SEL_OFF: regs_d.offset_dac_reg = cal_wr_in.data;
            ccl_pkg::CCL_SEL_SPAN: regs_d.span_dac_reg = cal_wr_in.data;
            default: regs_d = regs_d;
         endcase
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_q     <= ccl_pkg::CCL_ST_IDLE;
         step_q      <= ccl_pkg::CCL_STEP_LOCK;
         pend_q      <= 1'b1;
         idx_q       <= 8'h00;
         lo_q        <= 8'h00;
         lock_open_q <= 1'b0;
         lock_set_q  <= 1'b0;
         done_q      <= 1'b0;
         regs_q      <= {5{ccl_pkg::CCL_REG_RST}};
      end else begin
         state_q     <= state_d;
         step_q      <= step_d;
         pend_q      <= pend_d;
         idx_q       <= idx_d;
         lo_q        <= lo_d;
         lock_open_q <= lock_open_d;
         lock_set_q  <= lock_set_d;
         done_q      <= done_d;
         regs_q      <= regs_d;
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   assign cal_regs_out    = regs_q;
   assign temp_index_out  = idx_q;
   assign cal_access_out  = cal_access;
   assign locked_out      = lock_set_q & ~unlock_in;
   assign ext_res_sel_out =
      regs_q.config_word[ccl_pkg::CCL_CFG_EXT_RES_BIT];
   assign load_busy_out   = (state_q != ccl_pkg::CCL_ST_IDLE);
   assign load_done_out   = done_q;

endmodule

// [sim/ccl_loader_chk.sv]
/*
 * Port checker for the calibration coefficient loader.
 * Assumes it is bound to ccl_loader; one clock, reset async active high.
 */
`timescale 1ns/1ps
module ccl_loader_chk #(
   parameter int unsigned REFRESH_CYC = 64
) (
   input  wire logic                   clk_in,
   input  wire logic                   rst_in,
   input  wire logic [7:0]             temp_index_in,
   input  wire logic                   unlock_in,
   input  wire ccl_pkg::ccl_cal_wr_t   cal_wr_in,
   input  wire ccl_pkg::ccl_ee_prog_t  ee_prog_in,
   input  wire ccl_pkg::ccl_cal_regs_t cal_regs_out,
   input  wire logic [7:0]             temp_index_out,
   input  wire logic                   cal_access_out,
   input  wire logic                   locked_out,
   input  wire logic                   ext_res_sel_out,
   input  wire logic                   load_busy_out,
   input  wire logic                   load_done_out
);
   // ************************************************************
   // Properties
   // ************************************************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   property p_done_end;
      load_done_out |-> !load_busy_out && $past(load_busy_out);
   endproperty
   a_done_end: assert property (p_done_end)
      else $error("done without a finished pass");
   property p_done_pulse;
      load_done_out |=> !load_done_out;
   endproperty
   a_done_pulse: assert property (p_done_pulse)
      else $error("done longer than one cycle");
   property p_idx_max;
      temp_index_out <= 8'haf;
   endproperty
   a_idx_max: assert property (p_idx_max)
      else $error("index above top entry");
   property p_unlock;
      unlock_in |-> cal_access_out;
   endproperty
   a_unlock: assert property (p_unlock)
      else $error("override pin did not open access");
   property p_excl;
      locked_out && !unlock_in |-> !cal_access_out;
   endproperty
   a_excl: assert property (p_excl)
      else $error("locked and open at once");
   property p_nolock;
      cal_access_out && !cal_wr_in.valid |=> $stable(cal_regs_out);
   endproperty
   a_nolock: assert property (p_nolock)
      else $error("register refreshed while access open");
   property p_ext;
      ext_res_sel_out == cal_regs_out.config_word[0];
   endproperty
   a_ext: assert property (p_ext)
      else $error("resistor select differs from config bit");
   property p_ser_off;
      cal_wr_in.valid && cal_access_out && cal_wr_in.sel == 3'h4
      |=> cal_regs_out.offset_dac_reg == $past(cal_wr_in.data);
   endproperty
   a_ser_off: assert property (p_ser_off)
      else $error("serial offset write lost");
   property p_ser_span;
      cal_wr_in.valid && cal_access_out && cal_wr_in.sel == 3'h5
      |=> cal_regs_out.span_dac_reg == $past(cal_wr_in.data);
   endproperty
   a_ser_span: assert property (p_ser_span)
      else $error("serial span write lost");
   property p_refuse;
      cal_wr_in.valid && !cal_access_out && !load_busy_out
      |=> $stable(cal_regs_out);
   endproperty
   a_refuse: assert property (p_refuse)
      else $error("refused write changed a register");
   property p_quiet;
      !load_busy_out && !cal_wr_in.valid |=> $stable(cal_regs_out);
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("register changed outside a pass");
   property p_busy_min;
      $rose(load_busy_out) |-> load_busy_out [*2];
   endproperty
   a_busy_min: assert property (p_busy_min)
      else $error("pass shorter than the lock read");
   c_done: cover property (load_done_out);
   c_ser: cover property (cal_wr_in.valid && cal_access_out);
   c_ref: cover property (cal_wr_in.valid && !cal_access_out);
   c_open: cover property (cal_access_out && !unlock_in);
endmodule

// [sim/ccl_host_model.sv]
/*
 * Calibration host and store programmer driving the loader's far side.
 * Assumes the bench calls its tasks; outputs change just after an edge.
 */
`timescale 1ns/1ps
module ccl_host_model (
   input  wire logic             clk_in,
   output ccl_pkg::ccl_cal_wr_t  cal_wr_out,
   output ccl_pkg::ccl_ee_prog_t ee_prog_out
);
   // Released fields show inverted values so stale data never looks valid
   initial begin
      cal_wr_out  = '0;
      ee_prog_out = '0;
   end
   task automatic prog(input logic [9:0] a, input logic [7:0] d);
      @(posedge clk_in);
      ee_prog_out <= '{1'b1, a, d, 1'b0, 4'h0};
      @(posedge clk_in);
      ee_prog_out <= '{1'b0, ~a, ~d, 1'b0, 4'hf};
   endtask
   task automatic word(input logic [9:0] a, input logic [15:0] w);
      prog(a, w[7:0]);
      prog(a + 10'h001, w[15:8]);
   endtask
   task automatic erase(input logic [3:0] pg);
      @(posedge clk_in);
      ee_prog_out <= '{1'b0, 10'h000, 8'h00, 1'b1, pg};
      @(posedge clk_in);
      ee_prog_out <= '{1'b0, 10'h3ff, 8'hff, 1'b0, ~pg};
   endtask
   task automatic ser(input logic [2:0] s, input logic [15:0] d);
      @(posedge clk_in);
      cal_wr_out <= '{1'b1, s, d};
      @(posedge clk_in);
      cal_wr_out <= '{1'b0, ~s, ~d};
   endtask
endmodule

// [sim/test_ccl_loader.sv]
/*
 * Self-checking bench for the calibration coefficient loader.
 * Assumes a short refresh period; store contents start unknown.
 */
`timescale 1ns/1ps
module test_ccl_loader;
   localparam int unsigned REFRESH_CYC = 64;
   logic                   clk_in, rst_in, unlock;
   logic [7:0]             temp_index, idx_out, e;
   logic                   access, locked, ext_res, busy, done;
   ccl_pkg::ccl_cal_wr_t   cal_wr;
   ccl_pkg::ccl_ee_prog_t  ee_prog;
   ccl_pkg::ccl_cal_regs_t regs;
   int                     n_fail, n_checks;
   logic [15:0] sv [5] = '{16'h1110, 16'hffff, 16'h0000, 16'h8001, 16'h7ffe};
   logic [7:0] temps [5] = '{8'h00, 8'h10, 8'h90, 8'haf, 8'hff};
   logic [7:0] idxs [4] = '{8'h00, 8'h10, 8'h90, 8'haf};

   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end
   ccl_loader #(.REFRESH_CYC(REFRESH_CYC)) dut (
      .clk_in(clk_in), .rst_in(rst_in), .temp_index_in(temp_index),
      .unlock_in(unlock), .cal_wr_in(cal_wr), .ee_prog_in(ee_prog),
      .cal_regs_out(regs), .temp_index_out(idx_out),
      .cal_access_out(access), .locked_out(locked),
      .ext_res_sel_out(ext_res), .load_busy_out(busy),
      .load_done_out(done));
   ccl_host_model host (
      .clk_in(clk_in), .cal_wr_out(cal_wr), .ee_prog_out(ee_prog));

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic [9:0] off_a(input logic [7:0] i);
      return 10'h000 + {1'b0, i, 1'b0};
   endfunction
   function automatic logic [9:0] span_a(input logic [7:0] i);
      if (i < 8'h80) return 10'h200 + {1'b0, i, 1'b0};
      return 10'h1a0 + {2'b00, i[6:0], 1'b0};
   endfunction
   task automatic chk(input string nm, input logic [15:0] seen,
                      input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Bounded wait for completion pulses; c returns the last gap
   task automatic wait_done(input int k, output int c);
      repeat (k) begin
         c = 0;
         do begin
            @(posedge clk_in);
            #1;
            c++;
         end while (done !== 1'b1 && c < 400);
         if (done !== 1'b1) n_fail++;
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic final_report();
      if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      int c;
      n_fail = 0;
      n_checks = 0;
      rst_in = 1'b1;
      unlock = 1'b0;
      temp_index = 8'h00;
      repeat (8) @(posedge clk_in);
      rst_in <= 1'b0;
      for (int p = 0; p < 12; p++) host.erase(p[3:0]);
      host.prog(10'h16a, 8'hff);
      host.word(10'h160, 16'ha5c1);
      host.word(10'h164, 16'hffff);
      host.word(10'h168, 16'h0000);
      foreach (idxs[i]) begin
         host.word(off_a(idxs[i]), {8'h3c, idxs[i]});
         host.word(span_a(idxs[i]), {idxs[i], 8'hc3});
      end
      foreach (temps[i]) begin
         @(posedge clk_in);
         temp_index <= temps[i];
         e = (temps[i] > 8'haf) ? 8'haf : temps[i];
         wait_done(2, c);
         chk("temp_index", {8'h00, idx_out}, {8'h00, e});
         chk("offset_dac", regs.offset_dac_reg, {8'h3c, e});
         chk("span_dac", regs.span_dac_reg, {e, 8'hc3});
      end
      chk("config", regs.config_word, 16'ha5c1);
      chk("offset_tc", regs.offset_tc_dac_reg, 16'hffff);
      chk("span_tc", regs.span_tc_dac_reg, 16'h0000);
      chk("ext_res", {15'h0, ext_res}, 16'h0001);
      chk("locked", {15'h0, locked}, 16'h0001);
      wait_done(1, c);
      chk("refresh_gap", c[15:0], 16'(REFRESH_CYC));
      host.erase(4'h0);
      temp_index <= 8'h00;
      wait_done(2, c);
      chk("erased_off", regs.offset_dac_reg, 16'hffff);
      chk("kept_span", regs.span_dac_reg, 16'h00c3);
      @(posedge clk_in);
      unlock <= 1'b1;
      for (int s = 0; s < 5; s++) host.ser(3'(s + 1), sv[s]);
      host.ser(3'h0, 16'h5555);
      host.ser(3'h6, 16'h5555);
      cyc(3 * REFRESH_CYC);
      for (int s = 0; s < 5; s++) begin
         chk("ser_reg", regs[79-16*s -: 16], sv[s]);
      end
      chk("ext_res_ser", {15'h0, ext_res}, 16'h0000);
      @(posedge clk_in);
      unlock <= 1'b0;
      wait_done(1, c);
      host.ser(3'h4, 16'h0f0f);
      cyc(1);
      chk("refused", regs.offset_dac_reg, 16'hffff);
      chk("access_low", {15'h0, access}, 16'h0000);
      host.prog(10'h16a, 8'h00);
      cyc(2 * REFRESH_CYC);
      chk("open_access", {15'h0, access}, 16'h0001);
      host.ser(3'h5, 16'h2468);
      cyc(1);
      chk("open_write", regs.span_dac_reg, 16'h2468);
      host.prog(10'h16a, 8'h5a);
      cyc(2 * REFRESH_CYC);
      chk("other_lock", {14'h0, access, locked}, 16'h0000);
      final_report();
   end
   // Run needs some 1500 cycles; the limit leaves ample margin
   initial begin
      #80000;
      n_fail++;
      final_report();
   end
endmodule

bind ccl_loader ccl_loader_chk #(.REFRESH_CYC(REFRESH_CYC)) u_chk (
   .clk_in(clk_in), .rst_in(rst_in), .temp_index_in(temp_index_in),
   .unlock_in(unlock_in), .cal_wr_in(cal_wr_in), .ee_prog_in(ee_prog_in),
   .cal_regs_out(cal_regs_out), .temp_index_out(temp_index_out),
   .cal_access_out(cal_access_out), .locked_out(locked_out),
   .ext_res_sel_out(ext_res_sel_out), .load_busy_out(load_busy_out),
   .load_done_out(load_done_out));
